// >>> hdl/sarhp_regs.svh
/*
  timing counts and field positions of the converter host port.
  assumes inclusion by bare name from the design files.
*/
// Contract
// - start and read act only while chip select is low; else bus floats.
// - trigger low clears the approximation register; conversion begins on its release.
// - clear takes effect only with trigger, chip select and converter clock all low.
// - on release the register holds zero in the top bit, ones below.
// - each converter clock step keeps or flips the tested bit, then moves down.
// - only bit decisions advance on the external converter clock; clear and release follow the trigger.
// - done output goes low once the last bit is decided.
// - conversion time runs from the starting clock edge to the done edge.
// - chip select and read both low enable the result outputs.
// - data read keeps the bus floating until done is low.
// - status read puts the done flag on result bit 7.
// - status read keeps result bits 0 to 6 floating.
// - format choice high gives offset binary, low gives two's complement.
// - the result leaves over eight parallel three-state outputs.
`ifndef SARHP_REGS_SVH
`define SARHP_REGS_SVH
`define SARHP_WIDTH 8
`define SARHP_MSB 7
`define SARHP_STATUS_BIT 7
`define SARHP_STEPS 8
`define SARHP_FIRST_TRIAL 8'h7F
`define SARHP_PIN_IDLE 6'h3E
`endif

// >>> hdl/sarhp_pkg.sv
/*
  types shared by the converter host port modules.
  assumes nothing beyond the header.
*/
package sarhp_pkg;
  typedef enum logic [1:0] {SARHP_IDLE, SARHP_CLEAR, SARHP_CONV} sarhp_state_e;
endpackage

// >>> hdl/sarhp_sync_if.sv
/*
  interface carrying synchronised pin levels and edge events.
  assumes one clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
interface sarhp_sync_if;
  logic cs_n;
  logic trig_n;
  logic rd_n;
  logic sel;
  logic fmt;
  logic cclk;
  logic cclk_rise;
  modport src (output cs_n, trig_n, rd_n, sel, fmt, cclk, cclk_rise);
  modport dst (input cs_n, trig_n, rd_n, sel, fmt, cclk, cclk_rise);
endinterface
`default_nettype wire

// >>> hdl/sarhp_sync.sv
/*
  three-stage synchroniser for host pins and the converter clock pin.
  assumes pins asynchronous to CLOCK; a level counts once stages two and three agree.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sarhp_regs.svh"
module sarhp_sync (
  input wire logic clock, // system clock
  input wire logic rst_b, // async reset, active low
  input wire logic [5:0] pins, // cs_n, trig_n, rd_n, sel, fmt, cclk
  sarhp_sync_if.src so // filtered levels
);
  logic [5:0] s1_r;
  logic [5:0] s2_r;
  logic [5:0] s3_r;
  logic [5:0] lvl_r;
  logic rise_r;
  // three stages; stage one is read only by stage two
  // reset to idle pin levels, so no false converter clock edge follows reset
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      s1_r <= `SARHP_PIN_IDLE;
      s2_r <= `SARHP_PIN_IDLE;
      s3_r <= `SARHP_PIN_IDLE;
    end else begin
      s1_r <= pins;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end
  // accept a bit once stages two and three agree; cclk starts low
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      lvl_r <= `SARHP_PIN_IDLE;
      rise_r <= 1'b0;
    end else begin
      for (int i = 0; i < 6; i++) begin
        if (s2_r[i] == s3_r[i]) begin
          lvl_r[i] <= s2_r[i];
        end
      end
      rise_r <= (s2_r[0] == s3_r[0]) && s2_r[0] && !lvl_r[0];
    end
  end
  assign so.cs_n = lvl_r[5];
  assign so.trig_n = lvl_r[4];
  assign so.rd_n = lvl_r[3];
  assign so.sel = lvl_r[2];
  assign so.fmt = lvl_r[1];
  assign so.cclk = lvl_r[0];
  assign so.cclk_rise = rise_r;
endmodule
`default_nettype wire

// >>> hdl/sarhp_top.sv
/*
  control and host port of an 8-bit successive-approximation converter.
  assumes comparator level from the analog side, stable before each converter clock rise;
  the pad ring resolves the result bus from the per-bit enables.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sarhp_regs.svh"
module sarhp_top (
  input wire logic CLOCK, // 200 MHz system clock
  input wire logic RST_B, // async reset, active low
  input wire logic CHIP_SEL_N, // chip select, active low
  input wire logic TRIGGER_N, // start conversion, active low
  input wire logic READ_N, // read enable, active low
  input wire logic DATA_OR_FLAG_CHOICE, // 1 data read, 0 status read
  input wire logic FORMAT_CHOICE, // 1 offset binary, 0 two's complement
  input wire logic CONV_CLK, // external converter clock pin
  input wire logic COMP_IN, // comparator: 1 sets the tested bit, 0 clears it
  output logic [7:0] TRIAL_CODE, // code presented to the internal converter
  output logic DONE_N, // conversion complete, active low
  output logic [7:0] RESULT_BUS_O, // result bus drive value
  output logic [7:0] RESULT_BUS_OE // result bus per-bit output enable
);
  sarhp_sync_if sy ();
  logic [7:0] approximation_register_r;
  logic [7:0] bit_ptr_r;
  logic done_n_r;
  sarhp_pkg::sarhp_state_e state_r;
  logic [7:0] rbo_nxt;
  logic [7:0] rboe_nxt;
  logic [7:0] rbo_r;
  logic [7:0] rboe_r;
  logic clear_cond;

  // format conversion of the stored code
  function automatic logic [7:0] fmt_code(input logic [7:0] c, input logic ob);
    fmt_code = ob ? c : {~c[`SARHP_MSB], c[6:0]};
  endfunction

  sarhp_sync u_sync (
    .clock(CLOCK),
    .rst_b(RST_B),
    .pins({CHIP_SEL_N, TRIGGER_N, READ_N, DATA_OR_FLAG_CHOICE, FORMAT_CHOICE, CONV_CLK}),
    .so(sy)
  );

  assign clear_cond = !sy.trig_n && !sy.cs_n && !sy.cclk;

  // sequencer: clear, release, then one bit per converter clock rise
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      state_r <= sarhp_pkg::SARHP_IDLE;
      approximation_register_r <= 8'h00;
      bit_ptr_r <= 8'h00;
      done_n_r <= 1'b1;
    end else begin
      unique case (state_r)
        sarhp_pkg::SARHP_IDLE: begin
          if (clear_cond) begin
            state_r <= sarhp_pkg::SARHP_CLEAR;
            approximation_register_r <= 8'h00;
            done_n_r <= 1'b1;
          end
        end
        sarhp_pkg::SARHP_CLEAR: begin
          if (sy.trig_n) begin
            state_r <= sarhp_pkg::SARHP_CONV;
            approximation_register_r <= `SARHP_FIRST_TRIAL;
            bit_ptr_r <= 8'h80;
          end
        end
        sarhp_pkg::SARHP_CONV: begin
          if (clear_cond) begin
            state_r <= sarhp_pkg::SARHP_CLEAR; // restart mid-conversion
            approximation_register_r <= 8'h00;
          end else if (sy.cclk_rise) begin
            // decide tested bit; trial code has it zero only for the top bit, the comparator level replaces it
            approximation_register_r <= (approximation_register_r & ~bit_ptr_r)
              | (COMP_IN ? bit_ptr_r : 8'h00);
            bit_ptr_r <= bit_ptr_r >> 1;
            if (bit_ptr_r == 8'h01) begin
              state_r <= sarhp_pkg::SARHP_IDLE;
              done_n_r <= 1'b0;
            end
          end
        end
      endcase
    end
  end

  // host read port
  always_comb begin
    rbo_nxt = 8'h00;
    rboe_nxt = 8'h00;
    if (!sy.cs_n && !sy.rd_n) begin
      if (!sy.sel) begin
        rbo_nxt[`SARHP_STATUS_BIT] = done_n_r;
        rboe_nxt = 8'h80;
      end else if (!done_n_r) begin
        rbo_nxt = fmt_code(approximation_register_r, sy.fmt);
        rboe_nxt = 8'hFF;
      end
    end
  end

  // registered outputs
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      rbo_r <= 8'h00;
      rboe_r <= 8'h00;
    end else begin
      rbo_r <= rbo_nxt;
      rboe_r <= rboe_nxt;
    end
  end

  assign TRIAL_CODE = approximation_register_r;
  assign DONE_N = done_n_r;
  assign RESULT_BUS_O = rbo_r;
  assign RESULT_BUS_OE = rboe_r;

  // helper count of bit decisions in the running conversion, for the interval check
  logic [3:0] steps_r;
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      steps_r <= 4'h0;
    end else if (state_r != sarhp_pkg::SARHP_CONV) begin
      steps_r <= 4'h0;
    end else if (sy.cclk_rise && !clear_cond) begin
      steps_r <= steps_r + 4'h1;
    end
  end

  // trigger released after a clear: the conversion starts
  sequence s_release;
    state_r == sarhp_pkg::SARHP_CLEAR && sy.trig_n;
  endsequence

  // one bit decision of a running conversion
  sequence s_decide;
    state_r == sarhp_pkg::SARHP_CONV && sy.cclk_rise && !clear_cond;
  endsequence

  // host reading a finished result as data
  sequence s_data_read;
    !sy.cs_n && !sy.rd_n && sy.sel && !DONE_N;
  endsequence

  // deselected: the result bus floats
  AST_NO_DRIVE_DESELECTED: assert property (@(posedge CLOCK) disable iff (!RST_B)
    sy.cs_n |=> RESULT_BUS_OE == 8'h00) else $error("bus driven while deselected");

  // deselected: a trigger pulse clears nothing
  AST_NO_START_DESELECTED: assert property (@(posedge CLOCK) disable iff (!RST_B)
    (state_r == sarhp_pkg::SARHP_IDLE && sy.cs_n) |=> state_r != sarhp_pkg::SARHP_CLEAR)
    else $error("clear while deselected");

  // a clear empties the register and holds done high
  AST_CLEAR_ZERO: assert property (@(posedge CLOCK) disable iff (!RST_B)
    clear_cond |=> TRIAL_CODE == 8'h00 && DONE_N) else $error("clear missed");

  // no clear while the trigger stands high
  AST_CLEAR_NEEDS_TRIGGER: assert property (@(posedge CLOCK) disable iff (!RST_B)
    (state_r == sarhp_pkg::SARHP_IDLE && sy.trig_n) |=> state_r != sarhp_pkg::SARHP_CLEAR)
    else $error("clear without trigger");

  // converter clock high blocks the clear
  AST_NO_CLEAR_CLK_HIGH: assert property (@(posedge CLOCK) disable iff (!RST_B)
    (state_r == sarhp_pkg::SARHP_IDLE && sy.cclk) |=> state_r != sarhp_pkg::SARHP_CLEAR)
    else $error("clear with clock high");

  // first trial code on release
  AST_FIRST_TRIAL: assert property (@(posedge CLOCK) disable iff (!RST_B)
    s_release |=> TRIAL_CODE == `SARHP_FIRST_TRIAL) else $error("first trial code wrong");

  // the tested bit follows the comparator, the others hold
  AST_DECIDE: assert property (@(posedge CLOCK) disable iff (!RST_B)
    s_decide |=> (TRIAL_CODE & $past(bit_ptr_r)) == ($past(COMP_IN) ? $past(bit_ptr_r) : 8'h00)
      && (TRIAL_CODE & ~$past(bit_ptr_r)) == ($past(TRIAL_CODE) & ~$past(bit_ptr_r)))
    else $error("bit decision wrong");

  // in a conversion, the register moves only on a converter clock rise or a clear
  AST_STEP_ON_CLK: assert property (@(posedge CLOCK) disable iff (!RST_B)
    (state_r == sarhp_pkg::SARHP_CONV && !sy.cclk_rise && !clear_cond) |=> $stable(TRIAL_CODE))
    else $error("step without converter clock");

  // done falls right after the last decision
  AST_DONE_AFTER_LAST: assert property (@(posedge CLOCK) disable iff (!RST_B)
    (s_decide ##0 bit_ptr_r == 8'h01) |=> !DONE_N) else $error("done late");

  // done stays low until the next clear
  AST_DONE_STANDS: assert property (@(posedge CLOCK) disable iff (!RST_B)
    (!DONE_N && !clear_cond) |=> !DONE_N) else $error("done dropped early");

  // done falls after exactly the full count of decisions
  AST_INTERVAL: assert property (@(posedge CLOCK) disable iff (!RST_B)
    $fell(DONE_N) |-> steps_r == 4'(`SARHP_STEPS)) else $error("conversion length wrong");

  // select and read both low are needed to drive
  AST_READ_NEEDS_BOTH: assert property (@(posedge CLOCK) disable iff (!RST_B)
    (sy.cs_n || sy.rd_n) |=> RESULT_BUS_OE == 8'h00) else $error("bus driven without read");

  // a data read before done leaves the bus floating
  AST_DATA_WAIT: assert property (@(posedge CLOCK) disable iff (!RST_B)
    (sy.sel && DONE_N) |=> RESULT_BUS_OE == 8'h00) else $error("data before done");

  // status read: done on bit 7, the rest floating
  AST_STATUS: assert property (@(posedge CLOCK) disable iff (!RST_B)
    (!sy.cs_n && !sy.rd_n && !sy.sel) |=> RESULT_BUS_OE == 8'h80
      && RESULT_BUS_O[`SARHP_STATUS_BIT] == $past(DONE_N)) else $error("status read wrong");

  // offset binary data read drives all eight bits with the code
  AST_OFFSET_READ: assert property (@(posedge CLOCK) disable iff (!RST_B)
    (s_data_read ##0 sy.fmt) |=> RESULT_BUS_OE == 8'hFF && RESULT_BUS_O == $past(TRIAL_CODE))
    else $error("offset binary read wrong");

  // two's complement read inverts the top bit only
  AST_TWOS: assert property (@(posedge CLOCK) disable iff (!RST_B)
    (s_data_read ##0 !sy.fmt) |=> RESULT_BUS_OE == 8'hFF
      && RESULT_BUS_O == {~$past(TRIAL_CODE[7]), $past(TRIAL_CODE[6:0])})
    else $error("two's complement wrong");

  // done high from the start to the last decision
  AST_DONE_HIGH_CONV: assert property (@(posedge CLOCK) disable iff (!RST_B)
    state_r == sarhp_pkg::SARHP_CONV |-> DONE_N) else $error("done low mid conversion");

  // release enters conversion with done high
  AST_START_RAISES: assert property (@(posedge CLOCK) disable iff (!RST_B)
    s_release |=> DONE_N && state_r == sarhp_pkg::SARHP_CONV) else $error("start missed");
endmodule
`default_nettype wire

// >>> test/sarhp_host_model.sv
/*
  host and comparator model driving the converter pins.
  assumes the bench calls its tasks; pins change on clock falling edges.
*/
`timescale 1ns/1ps
`default_nettype none
module sarhp_host_model (
  input wire logic clock, // system clock
  output logic cs_n, // chip select, active low
  output logic trig_n, // start, active low
  output logic rd_n, // read, active low
  output logic sel, // data or flag choice
  output logic fmt, // format choice
  output logic cclk, // converter clock, idle low
  output logic comp // comparator level
);
  // idle host: deselected, converter clock still
  initial begin
    {cs_n, trig_n, rd_n, sel, fmt, cclk, comp} = 7'h79;
  end
  // pin levels stand for n system cycles
  task automatic hold(input int n);
    repeat (n) @(negedge clock);
  endtask
  // trigger pulse with chosen select and converter clock levels
  task automatic start(input logic c, input logic k);
    cs_n = c;
    cclk = k;
    hold(8);
    trig_n = 1'b0;
    hold(8);
    trig_n = 1'b1;
    hold(8);
    cclk = 1'b0;
    hold(8);
  endtask
  // one converter clock step with the given comparator level
  task automatic step(input logic b);
    comp = b;
    hold(8);
    cclk = 1'b1;
    hold(8);
    cclk = 1'b0;
  endtask
  // eight converter clocks, comparator gives target msb first
  task automatic run(input logic [7:0] t);
    for (int k = 7; k >= 0; k--) begin
      step(t[k]);
    end
    comp = ~t[0]; // level moves on once sampled
    hold(8);
  endtask
  // read held low until the bench has looked
  task automatic rd(input logic c, input logic s, input logic f);
    cs_n = c;
    sel = s;
    fmt = f;
    rd_n = 1'b0;
    hold(8);
  endtask
  // read and select released
  task automatic idle;
    rd_n = 1'b1;
    cs_n = 1'b1;
    hold(8);
  endtask
endmodule
`default_nettype wire

// >>> test/sarhp_top_bench.sv
/*
  self-checking bench of the converter host port.
  assumes the host model drives every pin; expectations queue to a watcher.
*/
`timescale 1ns/1ps
`default_nettype none
module sarhp_top_bench;
  typedef struct packed {logic [24:0] m; logic [24:0] v;} sarhp_note_s;
  localparam logic [24:0] DN = 25'h1000000;
  localparam logic [24:0] OE = 25'h0FF0000;
  localparam logic [24:0] DO = 25'h000FF00;
  localparam logic [24:0] TC = 25'h00000FF;
  logic CLOCK = 1'b0;
  logic RST_B = 1'b0;
  wire cs_n, trig_n, rd_n, sel, fmt, cclk, comp, done_n;
  wire [7:0] tc, bo, boe;
  wire [24:0] obs = {done_n, boe, bo, tc};
  sarhp_note_s q[$];
  sarhp_note_s n;
  event go;
  int n_errors = 0;
  int tests_run = 0;
  int cyc = 0;
  logic [31:0] seed = 32'hF14E;
  logic [31:0] s;
  logic [7:0] t;
  sarhp_top i_sarhp_top (.CLOCK(CLOCK), .RST_B(RST_B), .CHIP_SEL_N(cs_n),
    .TRIGGER_N(trig_n), .READ_N(rd_n), .DATA_OR_FLAG_CHOICE(sel),
    .FORMAT_CHOICE(fmt), .CONV_CLK(cclk), .COMP_IN(comp), .TRIAL_CODE(tc),
    .DONE_N(done_n), .RESULT_BUS_O(bo), .RESULT_BUS_OE(boe));
  sarhp_host_model i_sarhp_host_model (.clock(CLOCK), .cs_n(cs_n),
    .trig_n(trig_n), .rd_n(rd_n), .sel(sel), .fmt(fmt), .cclk(cclk),
    .comp(comp));
  // 200 MHz clock
  always #2.5 CLOCK = ~CLOCK;
  function automatic logic [31:0] rnd;
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic check(input logic [24:0] got, input logic [24:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t outputs %h expected %h", $time, got, exp);
    end
  endtask
  task automatic note(input logic [24:0] m, input logic [24:0] v);
    q.push_back('{m, v});
    ->go;
  endtask
  task automatic tally_and_finish;
    $display("errors %0d comparisons %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // watcher compares the oldest note with the settled outputs
  initial forever begin
    @(go);
    n = q.pop_front();
    check(obs & n.m, n.v & n.m);
  end
  // hang guard
  always @(posedge CLOCK) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      tally_and_finish();
    end
  end
  // main sequence
  initial begin
    repeat (16) @(posedge CLOCK);
    @(negedge CLOCK) RST_B = 1'b1;
    i_sarhp_host_model.hold(8);
    note(DN | OE | TC, {1'b1, 24'h0});
    for (int i = 0; i < 4; i++) begin
      s = rnd();
      t = s[7:0];
      i_sarhp_host_model.start(1'b0, 1'b0);
      note(DN | TC, {1'b1, 16'h0, 8'h7F});
      i_sarhp_host_model.rd(1'b0, 1'b0, 1'b1);
      note(OE | DO, {1'b0, 8'h80, 8'h80, 8'h0});
      i_sarhp_host_model.rd(1'b0, 1'b1, 1'b1);
      note(OE, 25'h0);
      i_sarhp_host_model.idle();
      i_sarhp_host_model.run(t);
      note(DN | TC, {1'b0, 16'h0, t});
      i_sarhp_host_model.rd(1'b0, 1'b1, i[0]);
      note(OE | DO, {1'b0, 8'hFF, i[0] ? t : {~t[7], t[6:0]}, 8'h0});
      i_sarhp_host_model.rd(1'b0, 1'b0, 1'b0);
      note(OE | 25'h8000, {1'b0, 8'h80, 8'h00, 8'h0});
      i_sarhp_host_model.rd(1'b1, 1'b1, 1'b1);
      note(OE, 25'h0);
      i_sarhp_host_model.idle();
    end
    // restart in mid conversion after two decided bits
    i_sarhp_host_model.start(1'b0, 1'b0);
    i_sarhp_host_model.step(1'b1);
    i_sarhp_host_model.step(1'b0);
    note(DN | TC, {1'b1, 16'h0, 8'hBF});
    i_sarhp_host_model.start(1'b0, 1'b0);
    note(DN | TC, {1'b1, 16'h0, 8'h7F});
    i_sarhp_host_model.run(t);
    note(DN | TC, {1'b0, 16'h0, t});
    i_sarhp_host_model.start(1'b1, 1'b0);
    note(DN | TC, {1'b0, 16'h0, t});
    i_sarhp_host_model.start(1'b0, 1'b1);
    note(DN | TC, {1'b0, 16'h0, t});
    i_sarhp_host_model.hold(1); // let the watcher take the last note
    tally_and_finish();
  end
endmodule
`default_nettype wire
